// File: hw/dbc_pkg.sv
/*
  Constants and types shared by the band control and activation block.
  Assumes a 16-bit register port with word addresses 4 bits wide.
*/
package dbc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int          NUM_SUB      = 4;
  localparam int          DATA_W       = 16;
  localparam int          ADDR_W       = 4;
  localparam int          CNT_W        = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [3:0]  ADDR_BAND    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h1;
  localparam logic [3:0]  ADDR_CLEAR   = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_EN  = 4'h3;
  localparam logic [3:0]  ADDR_CFG0    = 4'h4;
  localparam logic [3:0]  ADDR_CNT0    = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Band control fields and reset value
  localparam logic [15:0] BAND_RESET   = 16'h0000;
  localparam int          POS_CH1_FULL = 15;
  localparam int          POS_CH0_FULL = 14;
  localparam int          POS_CH1_ROUT = 11;
  localparam int          POS_CH0_ROUT = 9;
  localparam int          POS_CH1_MODE = 7;
  localparam int          POS_CH1_XEN  = 6;
  localparam int          POS_CH0_MODE = 5;
  localparam int          POS_CH0_XEN  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Sub-channel configuration fields, flag and count reset values
  localparam logic [5:0]  CFG_RESET    = 6'h00;
  localparam int          CFG_SRC_LSB  = 0;
  localparam int          CFG_BURST    = 2;
  localparam int          CFG_SINGLE   = 3;
  localparam int          CFG_ISEL_LSB = 4;
  localparam logic [1:0]  SRC_IRQ      = 2'h0;
  localparam logic [1:0]  SRC_EDGE     = 2'h1;
  localparam logic [1:0]  SRC_LEVEL    = 2'h2;
  localparam logic [1:0]  SRC_AUTO     = 2'h3;
  localparam logic [3:0]  FLAGS_RESET  = 4'h0;
  localparam logic [15:0] CNT_RESET    = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_READ,
    ST_WRITE,
    ST_SINGLE,
    ST_DEAD
  } dbc_state_type;

endpackage

// File: hw/dbc_req_if.sv
/*
  Request lines between the controller and one sub-channel request sensor.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface dbc_req_if;
  logic       en;
  logic [1:0] mode;
  logic       ext_n;
  logic       irq;
  logic       busy;
  logic       activate;
  logic       pending;

  modport sense (input en, input mode, input ext_n, input irq, input busy,
                 input activate, output pending);
  modport ctrl  (output en, output mode, output ext_n, output irq, output busy,
                 output activate, input pending);
endinterface

// File: hw/dbc_req_sense.sv
/*
  Request sensing for one sub-channel: on-chip interrupt, falling edge or
  low level of the external pin, or auto-request.
  Assumes ext_n is already synchronised and activate is a one-cycle pulse.
*/
`timescale 1ns/1ns
module dbc_req_sense (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Sub-channel request lines
  dbc_req_if.sense  rq
);

  logic irq_d_r;
  logic seen_high_r;
  logic armed_r;
  logic pending_r;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_d_r <= 1'b0;
    end else begin
      irq_d_r <= rq.irq;
    end
  end

  // High sampling for the next edge starts at activation
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seen_high_r <= 1'b0;
    end else if (!rq.en || rq.activate) begin
      seen_high_r <= 1'b0;
    end else if (rq.ext_n) begin
      seen_high_r <= 1'b1;
    end
  end

  // Acceptance reopens only once the transfer and its dead cycle are over
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed_r <= 1'b1;
    end else if (!rq.en) begin
      armed_r <= 1'b1;
    end else if (rq.activate) begin
      armed_r <= 1'b0;
    end else if (!armed_r && seen_high_r && !rq.busy) begin
      armed_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pending_r <= 1'b0;
    end else if (!rq.en) begin
      pending_r <= 1'b0;
    end else begin
      case (rq.mode)
        dbc_pkg::SRC_IRQ: begin
          // A new request in the activation cycle is kept
          if (rq.irq && !irq_d_r) begin
            pending_r <= 1'b1;
          end else if (rq.activate) begin
            pending_r <= 1'b0;
          end
        end
        dbc_pkg::SRC_EDGE: begin
          if (rq.activate) begin
            pending_r <= 1'b0;
          end else if (armed_r && !rq.ext_n) begin
            pending_r <= 1'b1;
          end
        end
        dbc_pkg::SRC_LEVEL: begin
          pending_r <= !rq.ext_n;
        end
        dbc_pkg::SRC_AUTO: begin
          pending_r <= 1'b1;
        end
        default: begin
          pending_r <= 1'b0;
        end
      endcase
    end
  end

  assign rq.pending = pending_r;

endmodule // dbc_req_sense

// File: hw/dbc_top.sv
/*
  Band control register and channel activation of a two-channel DMA
  controller with sub-channels A and B per channel.
  Assumes a bus arbiter answering bus_req with bus_grant, and on-chip
  interrupt flags that drop when irq_flag_clr pulses.
*/
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ns
module dbc_top (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hw_standby,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Activation sources
  input  wire logic [1:0]  ext_request_n,
  input  wire logic [3:0]  irq_src,
  output logic      [3:0]  irq_flag_clr,
  output logic      [3:0]  irq_to_cpu,
  // System bus
  input  wire logic        bus_grant,
  output logic             bus_req,
  output logic             bus_rd,
  output logic             bus_wr,
  output logic             bus_single,
  output logic      [1:0]  bus_sub,
  // Interrupt
  output logic             dma_irq
);

  localparam int NSUB = dbc_pkg::NUM_SUB;

  logic [15:0]             band_control_reg_r;
  logic [5:0]              cfg_r   [NSUB];
  logic [15:0]             cnt_r   [NSUB];
  logic [3:0]              status_r;
  logic [3:0]              irq_en_r;
  logic [1:0]              ext_meta_r;
  logic [1:0]              ext_sync_r;
  dbc_pkg::dbc_state_type  state_r;
  logic [1:0]              sel_r;
  logic                    cont_r;
  logic [3:0]              base_en;
  logic [3:0]              sub_en;
  logic [3:0]              pend;
  logic [3:0]              act_vec;
  logic [3:0]              end_evt;
  logic [3:0]              claimed;
  logic [3:0]              clr_vec;
  logic [1:0]              pick;
  logic                    unit_end;
  logic                    wr_clear;

  ////////////////////////////////////////////////////////////////////////////
  // External request pins enter through two flip-flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_meta_r <= 2'h3;
      ext_sync_r <= 2'h3;
    end else begin
      ext_meta_r <= ext_request_n;
      ext_sync_r <= ext_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sub-channel enables: B is idle while its channel uses full address mode
  always_comb begin
    for (int i = 0; i < NSUB; i++) begin
      if (i < 2) begin
        base_en[i] = band_control_reg_r[dbc_pkg::POS_CH0_XEN]
                   & band_control_reg_r[dbc_pkg::POS_CH0_MODE]
                   & ((i == 0) | ~band_control_reg_r[dbc_pkg::POS_CH0_FULL]);
      end else begin
        base_en[i] = band_control_reg_r[dbc_pkg::POS_CH1_XEN]
                   & band_control_reg_r[dbc_pkg::POS_CH1_MODE]
                   & ((i == 2) | ~band_control_reg_r[dbc_pkg::POS_CH1_FULL]);
      end
      sub_en[i] = base_en[i] & (cnt_r[i] != dbc_pkg::CNT_RESET);
    end
  end

  // Sources that an enabled, routed sub-channel takes away from the CPU
  always_comb begin
    claimed = 4'h0;
    for (int i = 0; i < NSUB; i++) begin
      if (base_en[i] && cfg_r[i][dbc_pkg::CFG_SRC_LSB +: 2] == dbc_pkg::SRC_IRQ
          && band_control_reg_r[(i < 2) ? dbc_pkg::POS_CH0_ROUT
                                        : dbc_pkg::POS_CH1_ROUT]) begin
        claimed[cfg_r[i][dbc_pkg::CFG_ISEL_LSB +: 2]] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request sensors
  genvar gi;
  generate
    for (gi = 0; gi < NSUB; gi++) begin : g_sub
      dbc_req_if rq ();
      assign rq.en       = sub_en[gi];
      assign rq.mode     = cfg_r[gi][dbc_pkg::CFG_SRC_LSB +: 2];
      assign rq.ext_n    = ext_sync_r[gi / 2];
      assign rq.irq      = irq_src[cfg_r[gi][dbc_pkg::CFG_ISEL_LSB +: 2]];
      assign rq.busy     = (state_r != dbc_pkg::ST_IDLE) && (sel_r == 2'(gi));
      assign rq.activate = act_vec[gi];
      dbc_req_sense u_sense (
        .clock (clock),
        .rst   (rst),
        .rq    (rq)
      );
      assign pend[gi] = rq.pending;
    end
  endgenerate

  // Lowest index wins: 0A, 0B, 1A, 1B
  always_comb begin
    pick = 2'h0;
    for (int i = NSUB - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = 2'(i);
      end
    end
  end

  always_comb begin
    act_vec = 4'h0;
    clr_vec = 4'h0;
    if (state_r == dbc_pkg::ST_IDLE && pend != 4'h0) begin
      act_vec[pick] = 1'b1;
      if (cfg_r[pick][dbc_pkg::CFG_SRC_LSB +: 2] == dbc_pkg::SRC_IRQ
          && band_control_reg_r[(pick < 2'h2) ? dbc_pkg::POS_CH0_ROUT
                                              : dbc_pkg::POS_CH1_ROUT]) begin
        clr_vec[cfg_r[pick][dbc_pkg::CFG_ISEL_LSB +: 2]] = 1'b1;
      end
    end
  end

  assign unit_end = (state_r == dbc_pkg::ST_WRITE) || (state_r == dbc_pkg::ST_SINGLE);

  always_comb begin
    end_evt = 4'h0;
    if (unit_end && cnt_r[sel_r] == 16'h0001) begin
      end_evt[sel_r] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r    <= dbc_pkg::ST_IDLE;
      sel_r      <= 2'h0;
      cont_r     <= 1'b0;
      bus_req    <= 1'b0;
      bus_rd     <= 1'b0;
      bus_wr     <= 1'b0;
      bus_single <= 1'b0;
    end else begin
      case (state_r)
        dbc_pkg::ST_IDLE: begin
          if (pend != 4'h0) begin
            sel_r      <= pick;
            bus_req    <= 1'b1;
            bus_single <= cfg_r[pick][dbc_pkg::CFG_SINGLE];
            state_r    <= dbc_pkg::ST_REQ;
          end
        end
        dbc_pkg::ST_REQ: begin
          if (!sub_en[sel_r] || (!pend[sel_r]
              && cfg_r[sel_r][dbc_pkg::CFG_SRC_LSB +: 2] == dbc_pkg::SRC_LEVEL)) begin
            bus_req <= 1'b0;
            state_r <= dbc_pkg::ST_IDLE;
          end else if (bus_grant) begin
            if (bus_single) begin
              bus_rd  <= 1'b1;
              bus_wr  <= 1'b1;
              state_r <= dbc_pkg::ST_SINGLE;
            end else begin
              bus_rd  <= 1'b1;
              state_r <= dbc_pkg::ST_READ;
            end
          end
        end
        dbc_pkg::ST_READ: begin
          bus_rd  <= 1'b0;
          bus_wr  <= 1'b1;
          state_r <= dbc_pkg::ST_WRITE;
        end
        dbc_pkg::ST_WRITE, dbc_pkg::ST_SINGLE: begin
          bus_rd  <= 1'b0;
          bus_wr  <= 1'b0;
          cont_r  <= cfg_r[sel_r][dbc_pkg::CFG_BURST] && cnt_r[sel_r] > 16'h0001
                  && cfg_r[sel_r][dbc_pkg::CFG_SRC_LSB +: 2] == dbc_pkg::SRC_AUTO;
          state_r <= dbc_pkg::ST_DEAD;
        end
        dbc_pkg::ST_DEAD: begin
          if (cont_r && sub_en[sel_r]) begin
            bus_rd  <= 1'b1;
            bus_wr  <= bus_single;
            state_r <= bus_single ? dbc_pkg::ST_SINGLE : dbc_pkg::ST_READ;
          end else begin
            bus_req <= 1'b0;
            state_r <= dbc_pkg::ST_IDLE;
          end
        end
        default: begin
          bus_req <= 1'b0;
          state_r <= dbc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_sub <= 2'h0;
    end else begin
      bus_sub <= (state_r == dbc_pkg::ST_IDLE) ? pick : sel_r;
    end
  end

  // Flag clears pulse once; CPU routing follows the live sources
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_flag_clr <= dbc_pkg::FLAGS_RESET;
      irq_to_cpu   <= dbc_pkg::FLAGS_RESET;
    end else begin
      irq_flag_clr <= clr_vec;
      irq_to_cpu   <= irq_src & ~claimed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      band_control_reg_r <= dbc_pkg::BAND_RESET;
    end else if (hw_standby) begin
      band_control_reg_r <= dbc_pkg::BAND_RESET;
    end else if (reg_wr && reg_addr == dbc_pkg::ADDR_BAND) begin
      band_control_reg_r <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NSUB; i++) begin
        cfg_r[i] <= dbc_pkg::CFG_RESET;
      end
    end else if (reg_wr && reg_addr[3:2] == dbc_pkg::ADDR_CFG0[3:2]) begin
      cfg_r[reg_addr[1:0]] <= reg_wdata[5:0];
    end
  end

  // A software write to a count beats the decrement in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NSUB; i++) begin
        cnt_r[i] <= dbc_pkg::CNT_RESET;
      end
    end else begin
      for (int i = 0; i < NSUB; i++) begin
        if (reg_wr && reg_addr == dbc_pkg::ADDR_CNT0 + 4'(i)) begin
          cnt_r[i] <= reg_wdata;
        end else if (unit_end && sel_r == 2'(i)) begin
          cnt_r[i] <= cnt_r[i] - 16'h0001;
        end
      end
    end
  end

  assign wr_clear = reg_wr && reg_addr == dbc_pkg::ADDR_CLEAR;

  // Completion set wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_r <= dbc_pkg::FLAGS_RESET;
    end else begin
      status_r <= end_evt | (status_r & ~(wr_clear ? reg_wdata[3:0] : 4'h0));
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_en_r <= dbc_pkg::FLAGS_RESET;
    end else if (reg_wr && reg_addr == dbc_pkg::ADDR_IRQ_EN) begin
      irq_en_r <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dma_irq <= 1'b0;
    end else begin
      dma_irq <= (status_r & irq_en_r) != 4'h0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == dbc_pkg::ADDR_BAND) begin
      reg_rdata <= band_control_reg_r;
    end else if (reg_addr == dbc_pkg::ADDR_STATUS) begin
      reg_rdata <= {12'h000, status_r};
    end else if (reg_addr == dbc_pkg::ADDR_IRQ_EN) begin
      reg_rdata <= {12'h000, irq_en_r};
    end else if (reg_addr[3:2] == dbc_pkg::ADDR_CFG0[3:2]) begin
      reg_rdata <= {10'h000, cfg_r[reg_addr[1:0]]};
    end else if (reg_addr[3:2] == dbc_pkg::ADDR_CNT0[3:2]) begin
      reg_rdata <= cnt_r[reg_addr[1:0]];
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // dbc_top

// File: dv/dbc_top_asserts.sv
/*
  Port-level checks on dbc_top.
  Assumes one clock, active-high reset, and an arbiter that holds grant
  while the request stands.
*/
`timescale 1ns/1ns
module dbc_top_asserts (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        hw_standby,
  // Register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Sources and bus
  input wire logic [3:0]  irq_src,
  input wire logic [3:0]  irq_flag_clr,
  input wire logic [3:0]  irq_to_cpu,
  input wire logic        bus_grant,
  input wire logic        bus_req,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic        bus_single
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////
  sequence band_wr;
    reg_wr && reg_addr == dbc_pkg::ADDR_BAND && !hw_standby;
  endsequence
  sequence band_rd;
    reg_rd && reg_addr == dbc_pkg::ADDR_BAND;
  endsequence
  sequence dual_tail;
    (bus_wr && !bus_rd) ##1 (!bus_wr && !bus_rd);
  endsequence

  //////////////////////////////////////////////////
  standby_clear_a: assert property (
    (hw_standby && !reg_wr) ##1 band_rd |=> reg_rdata == dbc_pkg::BAND_RESET
  ) else $error("band not cleared by standby");
  band_rdback_a: assert property (
    band_wr ##1 (!reg_wr && !hw_standby) ##1 band_rd |=> reg_rdata == $past(reg_wdata, 3)
  ) else $error("band read differs from write");
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 16'h0000
  ) else $error("read data outside read slot");
  dual_unit_a: assert property (
    bus_rd && !bus_wr |=> dual_tail
  ) else $error("dual unit order broken");
  single_unit_a: assert property (
    bus_rd && bus_wr |-> bus_single ##1 (!bus_rd && !bus_wr)
  ) else $error("single unit malformed");
  bus_owned_a: assert property (
    bus_rd || bus_wr |-> bus_req && $past(bus_grant)
  ) else $error("bus cycle without grant");
  grant_rd_a: assert property (
    $rose(bus_grant) && bus_req |=> bus_rd
  ) else $error("no read after grant");
  req_fall_a: assert property (
    $fell(bus_req) |-> !$past(bus_rd) && !$past(bus_wr)
  ) else $error("bus dropped mid unit");
  flag_pulse_a: assert property (
    irq_flag_clr != 4'h0 |=> irq_flag_clr == 4'h0
  ) else $error("flag clear longer than a cycle");
  cpu_gate_a: assert property (
    (irq_to_cpu & ~$past(irq_src)) == 4'h0
  ) else $error("cpu interrupt without source");
endmodule // dbc_top_asserts

// File: dv/dbc_partner.sv
/*
  Far side of dbc_top: bus arbiter and request pin driver.
  Assumes the bench pulses edge_go once per wanted falling edge.
*/
`timescale 1ns/1ns
module dbc_partner (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Arbiter
  input wire logic        bus_req,
  input wire logic [3:0]  grant_dly,
  output logic            bus_grant,
  // Request pins
  input wire logic [1:0]  edge_go,
  input wire logic [1:0]  hold_low,
  output logic     [1:0]  ext_request_n
);
  int wait_c;
  int pend [2];
  int low_c [2];
  int high_c [2];

  // Grant only after the programmed delay; taken back once released
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_grant <= 1'b0;
      wait_c    <= 0;
    end else if (!bus_req) begin
      bus_grant <= 1'b0;
      wait_c    <= 0;
    end else if (wait_c >= int'(grant_dly)) begin
      bus_grant <= 1'b1;
    end else begin
      wait_c <= wait_c + 1;
    end
  end

  // Edges are queued so the bench never has to pace them itself
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend   <= '{0, 0};
      low_c  <= '{0, 0};
      high_c <= '{0, 0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        high_c[i] <= ext_request_n[i] ? high_c[i] + 1 : 0;
        if (low_c[i] != 0) begin
          low_c[i] <= low_c[i] - 1;
          pend[i]  <= pend[i] + int'(edge_go[i]);
        end else if (pend[i] != 0 && high_c[i] > 5 && !bus_req) begin
          low_c[i] <= 3;
          pend[i]  <= pend[i] - 1 + int'(edge_go[i]);
        end else begin
          pend[i] <= pend[i] + int'(edge_go[i]);
        end
      end
    end
  end

  assign ext_request_n = ~(hold_low | {low_c[1] != 0, low_c[0] != 0});
endmodule // dbc_partner

// File: dv/tb_dbc_top.sv
/*
  Self-checking bench for dbc_top with unit counting model.
  Assumes dbc_partner and dbc_top_asserts are compiled first.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_dbc_top;
  logic        clock = 0, rst = 1, hw_standby = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0]  reg_addr = 4'h0, irq_src = 4'h0, grant_dly = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, rv, reg_rdata;
  logic [1:0]  edge_go = 2'h0, hold_low = 2'h0, bus_sub, ext_request_n;
  logic [3:0]  irq_flag_clr, irq_to_cpu;
  logic        bus_grant, bus_req, bus_rd, bus_wr, bus_single, dma_irq;
  int          error_cnt = 0, check_count = 0, falls = 0, clrs = 0, k, f;
  int          units [4] = '{0, 0, 0, 0};
  int          exp_u [4] = '{0, 0, 0, 0};
  logic [1:0]  ord [$];

  always #50 clock = ~clock;

  dbc_top dbc_top_inst (.clock, .rst, .hw_standby, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ext_request_n, .irq_src, .irq_flag_clr, .irq_to_cpu,
    .bus_grant, .bus_req, .bus_rd, .bus_wr, .bus_single, .bus_sub, .dma_irq);
  dbc_partner dbc_partner_inst (.clock, .rst, .bus_req, .grant_dly, .bus_grant,
    .edge_go, .hold_low, .ext_request_n);

  // Units seen per sub-channel, in order
  always @(posedge clock) begin
    if (bus_rd) begin
      units[bus_sub]++;
      ord.push_back(bus_sub);
    end
    if ($fell(bus_req)) falls++;
    if (irq_flag_clr[1]) clrs++;
  end

  //////////////////////////////////////////////////
  task automatic print_verdict;
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Data are compared one edge after the read slot ends
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    `CHK(reg_rdata, e)
  endtask

  task automatic run(input int s, input int n);
    exp_u[s] += n;
    for (k = 0; k < 800 && units[s] != exp_u[s]; k++) @(posedge clock);
    if (k == 800) begin
      error_cnt++;
      print_verdict();
    end
    repeat (8) @(posedge clock);
    `CHK(units[s], exp_u[s])
  endtask

  //////////////////////////////////////////////////
  initial begin
    rv = 16'($urandom(32'h48AB1175));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(4'h0, 16'h0000);
    rv = 16'($urandom);
    wr(4'h0, rv);
    rd(4'h0, rv);
    hw_standby <= 1'b1;
    rd(4'h0, 16'h0000);
    hw_standby <= 1'b0;
    rd(4'hF, 16'h0000);
    // Auto cycle steal with slow grant and end interrupt
    grant_dly <= 4'h3;
    wr(4'h4, 16'h0003);
    wr(4'h8, 16'h0002);
    wr(4'h3, 16'h0001);
    wr(4'h0, 16'h0030);
    f = falls;
    run(0, 2);
    `CHK(falls - f, 2)
    rd(4'h8, 16'h0000);
    rd(4'h1, 16'h0001);
    `CHK(dma_irq, 1'b1)
    wr(4'h2, 16'h0001);
    rd(4'h1, 16'h0000);
    `CHK(dma_irq, 1'b0)
    // Burst keeps the bus; end interrupt masked
    grant_dly <= 4'($urandom % 4);
    wr(4'h3, 16'h0000);
    wr(4'h5, 16'h0007);
    wr(4'h9, 16'h0003);
    f = falls;
    run(1, 3);
    `CHK(falls - f, 1)
    rd(4'h1, 16'h0002);
    `CHK(dma_irq, 1'b0)
    // Single address on 1A, then 1B held off by full address
    wr(4'h6, 16'h000B);
    wr(4'hA, 16'h0001);
    wr(4'h0, 16'h00F0);
    run(2, 1);
    wr(4'h0, 16'h80F0);
    wr(4'h7, 16'h0003);
    wr(4'hB, 16'h0001);
    repeat (30) @(posedge clock);
    `CHK(units[3], exp_u[3])
    wr(4'h0, 16'h00F0);
    run(3, 1);
    // Edge sensing: ignored before enable, one unit per edge after
    wr(4'h0, 16'h00C0);
    wr(4'h4, 16'h0001);
    wr(4'h8, 16'h0003);
    edge_go <= 2'h1;
    @(posedge clock);
    edge_go <= 2'h0;
    repeat (30) @(posedge clock);
    `CHK(units[0], exp_u[0])
    wr(4'h0, 16'h00F0);
    edge_go <= 2'h1;
    repeat (2) @(posedge clock);
    edge_go <= 2'h0;
    run(0, 2);
    rd(4'h8, 16'h0001);
    edge_go <= 2'h1;
    @(posedge clock);
    edge_go <= 2'h0;
    run(0, 1);
    // Level sensing on the channel 1 pin
    wr(4'h6, 16'h0002);
    wr(4'hA, 16'h0003);
    f = falls;
    hold_low <= 2'h2;
    run(2, 3);
    hold_low <= 2'h0;
    `CHK(falls - f, 3)
    // Pin released after two units: the rest waits, count is kept
    grant_dly <= 4'h3;
    wr(4'hA, 16'h0008);
    f = units[2];
    exp_u[2] += 2;
    hold_low <= 2'h2;
    for (k = 0; k < 800 && units[2] < f + 2; k++) @(posedge clock);
    hold_low <= 2'h0;
    if (k == 800) begin
      error_cnt++;
      print_verdict();
    end
    repeat (50) @(posedge clock);
    `CHK(units[2], exp_u[2])
    rd(4'hA, 16'h0006);
    // One source on two channels, routed to the controller
    wr(4'h4, 16'h0010);
    wr(4'h6, 16'h0010);
    wr(4'h8, 16'h0001);
    wr(4'hA, 16'h0001);
    wr(4'h0, 16'h0AF0);
    ord.delete();
    irq_src <= 4'h2;
    run(0, 1);
    run(2, 1);
    `CHK(ord[0], 2'h0)
    `CHK(ord[1], 2'h2)
    `CHK(clrs != 0, 1'b1)
    `CHK(irq_to_cpu[1], 1'b0)
    irq_src <= 4'h0;
    // Routing off: transfer runs, flag left for the CPU
    f = clrs;
    wr(4'h8, 16'h0001);
    wr(4'h0, 16'h00F0);
    irq_src <= 4'h2;
    run(0, 1);
    `CHK(clrs - f, 0)
    `CHK(irq_to_cpu[1], 1'b1)
    irq_src <= 4'h0;
    // Transfer disabled: nothing starts, CPU gets the interrupt
    wr(4'h8, 16'h0001);
    wr(4'h0, 16'h0000);
    irq_src <= 4'h2;
    repeat (30) @(posedge clock);
    `CHK(units[0], exp_u[0])
    `CHK(irq_to_cpu[1], 1'b1)
    print_verdict();
  end
endmodule // tb_dbc_top

bind dbc_top dbc_top_asserts dbc_top_asserts_inst (.clock, .rst, .hw_standby, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_src, .irq_flag_clr, .irq_to_cpu,
  .bus_grant, .bus_req, .bus_rd, .bus_wr, .bus_single);
